// *** include/pst_defines.vh ***
// Constants for the status and telemetry command bank
`ifndef PST_DEFINES_VH
`define PST_DEFINES_VH
`define PST_CMD_CLEAR_FAULTS 8'h03
`define PST_CMD_STATUS_BYTE  8'h78
`define PST_CMD_STATUS_CML   8'h7e
`define PST_CMD_VENDOR_STAT  8'h80
`define PST_CMD_VIN_READ     8'h88
`define PST_CMD_VOUT_READ    8'h8b
`define PST_CMD_ALERT_MASK   8'h1b
`define PST_BIT_POR          7
`define PST_BIT_SELF         6
`define PST_BIT_RESTART      3
`define PST_BIT_BACKCH       2
`define PST_BIT_SYNC         1
`define PST_BIT_IVC          7
`define PST_BIT_SB_CML       1
`define PST_VENDOR_RW_MASK   8'h8e
`define PST_CML_RW_MASK      8'hfa
`define PST_STAT_RESET       8'h00
`define PST_PHASE_ALL        8'hff
`endif

// *** core/pst_latch_bits.v ***
// Write-one-to-clear latched flag group
`timescale 1ns/1ps
`default_nettype none
module pst_latch_bits #(
  parameter W = 8
) (
  input  wire         clock_in,
  input  wire         rst_n_in,
  input  wire [W-1:0] set_in,
  input  wire [W-1:0] w1c_in,
  input  wire         clear_all_in,
  input  wire [W-1:0] keep_in,
  output reg  [W-1:0] flags_out
);
  reg [W-1:0] flags_nxt;
  always @* begin
    // Set wins over clear so a coincident event is kept
    flags_nxt = (flags_out & ~w1c_in & {W{~clear_all_in}}) | set_in;
    flags_nxt = flags_nxt & keep_in;
  end
  always @(posedge clock_in) begin
    if (!rst_n_in) begin
      flags_out <= {W{1'b0}};
    end else begin
      flags_out <= flags_nxt;
    end
  end
endmodule
`default_nettype wire

// *** core/pst_status_telemetry.v ***
// Vendor status, communication status and voltage telemetry commands
`timescale 1ns/1ps
`default_nettype none
`include "pst_defines.vh"
module pst_status_telemetry #(
  parameter STACK = 4
) (
  input  wire        clock_in,
  input  wire        rst_n_in,
  // Command port from the bus front end
  input  wire        cmd_wr_in,
  input  wire        cmd_rd_in,
  input  wire [7:0]  cmd_code_in,
  input  wire [15:0] cmd_wdata_in,
  input  wire [7:0]  phase_in,
  // Fault and status events from the device
  input  wire        trim_bad_in,
  input  wire        store_sum_bad_in,
  input  wire        pin_detect_bad_in,
  input  wire        self_check_busy_in,
  input  wire [3:0]  follower_expected_in,
  input  wire [3:0]  follower_answered_in,
  input  wire        output_restart_event_in,
  input  wire        back_channel_link_fault_in,
  input  wire        sync_fault_in,
  // Measurements
  input  wire        sample_done_in,
  input  wire [15:0] vin_local_in,
  input  wire [63:0] vin_stack_in,
  input  wire [15:0] vout_linear_in,
  input  wire [15:0] output_sense_pin_in,
  input  wire        loop_follower_in,
  output reg  [15:0] rdata_out,
  output reg         rvalid_out,
  output reg         unmapped_out,
  output reg         alert_n_out,
  output reg  [7:0]  status_byte_out
);
  // ==========================================================
  // Helper functions
  // One decoder for every write-side command match; the read case decodes on its own
  function cmd_hit;
    input [7:0] code;
    input [7:0] ref_code;
    begin
      cmd_hit = (code == ref_code);
    end
  endfunction

  // Write-one-to-clear data only counts on a write to that command
  function [7:0] w1c_bits;
    input       hit;
    input [7:0] data;
    begin
      if (hit) begin
        w1c_bits = data;
      end else begin
        w1c_bits = 8'h00;
      end
    end
  endfunction

  // Picks one 16-bit member word out of the packed stack bus
  function [15:0] lane_pick;
    input [63:0] bus;
    input [1:0]  idx;
    begin
      case (idx)
        2'h0:    lane_pick = bus[15:0];
        2'h1:    lane_pick = bus[31:16];
        2'h2:    lane_pick = bus[47:32];
        2'h3:    lane_pick = bus[63:48];
        default: lane_pick = 16'h0000;
      endcase
    end
  endfunction

  // Stack bus holds four members; an absent phase reads zero
  function [15:0] phase_word;
    input [7:0]  ph;
    input [15:0] local_w;
    input [63:0] stack_w;
    begin
      if (ph == `PST_PHASE_ALL) begin
        phase_word = local_w;
      end else if (ph < STACK) begin
        phase_word = lane_pick(stack_w, ph[1:0]);
      end else begin
        phase_word = 16'h0000;
      end
    end
  endfunction

  // ==========================================================
  // Vendor and communication status bits
  wire [7:0] vend_set;
  wire [7:0] vend_q;
  wire [7:0] cml_set;
  wire [7:0] cml_q;
  wire       clr_all;
  wire       wr_vend;
  wire       wr_cml;
  wire       wr_ro;
  reg  [7:0] vend_mask_r;
  reg  [7:0] cml_mask_r;

  assign clr_all = cmd_wr_in &
                   cmd_hit(cmd_code_in, `PST_CMD_CLEAR_FAULTS);
  assign wr_vend = cmd_wr_in &
                   cmd_hit(cmd_code_in, `PST_CMD_VENDOR_STAT);
  assign wr_cml  = cmd_wr_in &
                   cmd_hit(cmd_code_in, `PST_CMD_STATUS_CML);
  // Telemetry words are read-only; a write is an invalid command
  assign wr_ro   = cmd_wr_in &
                   (cmd_hit(cmd_code_in, `PST_CMD_VIN_READ) |
                    cmd_hit(cmd_code_in, `PST_CMD_VOUT_READ));

  assign vend_set[`PST_BIT_POR] = trim_bad_in | store_sum_bad_in |
                                  pin_detect_bad_in;
  assign vend_set[6] = 1'b0;
  assign vend_set[5:4] = 2'b00;
  assign vend_set[`PST_BIT_RESTART] = output_restart_event_in;
  assign vend_set[`PST_BIT_BACKCH] = back_channel_link_fault_in;
  assign vend_set[`PST_BIT_SYNC] = sync_fault_in;
  assign vend_set[0] = 1'b0;
  assign cml_set = {wr_ro, 7'h00};

  pst_latch_bits #(.W(8)) u_vend (
    .clock_in     (clock_in),
    .rst_n_in     (rst_n_in),
    .set_in       (vend_set),
    .w1c_in       (w1c_bits(wr_vend, cmd_wdata_in[7:0])),
    .clear_all_in (clr_all),
    .keep_in      (`PST_VENDOR_RW_MASK),
    .flags_out    (vend_q)
  );

  pst_latch_bits #(.W(8)) u_cml (
    .clock_in     (clock_in),
    .rst_n_in     (rst_n_in),
    .set_in       (cml_set),
    .w1c_in       (w1c_bits(wr_cml, cmd_wdata_in[7:0])),
    .clear_all_in (clr_all),
    .keep_in      (`PST_CML_RW_MASK),
    .flags_out    (cml_q)
  );

  // ==========================================================
  // Live self-check bit and alert masks
  wire       self_live;
  wire [7:0] vend_view;
  wire       vend_alert;
  wire       cml_alert;

  assign self_live = self_check_busy_in |
         |(follower_expected_in & ~follower_answered_in);
  assign vend_view = vend_q | {1'b0, self_live, 6'h00};
  // Mask low byte covers vendor bits, high byte the comm bits
  assign vend_alert = |(vend_q & ~vend_mask_r);
  assign cml_alert  = |(cml_q & ~cml_mask_r);

  always @(posedge clock_in) begin
    if (!rst_n_in) begin
      vend_mask_r <= `PST_STAT_RESET;
      cml_mask_r  <= `PST_STAT_RESET;
    end else if (cmd_wr_in &&
                 cmd_hit(cmd_code_in, `PST_CMD_ALERT_MASK)) begin
      vend_mask_r <= cmd_wdata_in[7:0] & `PST_VENDOR_RW_MASK;
      cml_mask_r  <= cmd_wdata_in[15:8] & `PST_CML_RW_MASK;
    end
  end

  // ==========================================================
  // Telemetry snapshots
  reg  [15:0] vin_loc_r;
  reg  [63:0] vin_stk_r;
  reg  [15:0] vout_r;
  reg  [15:0] vout_pick;
  wire [15:0] vin_sel;

  // Follower reports its sense pin as is; scale factor plays no part
  always @* begin
    if (loop_follower_in) begin
      vout_pick = output_sense_pin_in;
    end else begin
      vout_pick = vout_linear_in;
    end
  end

  // Every member moves in one edge, so no torn reads, and a phase
  // change after the sample still reads words of that one sample
  always @(posedge clock_in) begin
    if (!rst_n_in) begin
      vin_loc_r <= 16'h0000;
      vin_stk_r <= 64'h0000000000000000;
      vout_r    <= 16'h0000;
    end else if (sample_done_in) begin
      vin_loc_r <= vin_local_in;
      vin_stk_r <= vin_stack_in;
      vout_r    <= vout_pick;
    end
  end

  // Phase is applied when the host reads, as it stands then
  assign vin_sel = phase_word(phase_in, vin_loc_r, vin_stk_r);

  // ==========================================================
  // Read data and summary outputs
  reg [15:0] rd_nxt;
  reg        um_nxt;

  always @* begin
    rd_nxt = 16'h0000;
    um_nxt = 1'b0;
    case (cmd_code_in)
      `PST_CMD_VENDOR_STAT: rd_nxt = {8'h00, vend_view};
      `PST_CMD_STATUS_CML:  rd_nxt = {8'h00, cml_q};
      `PST_CMD_VIN_READ:    rd_nxt = vin_sel;
      `PST_CMD_VOUT_READ:   rd_nxt = vout_r;
      `PST_CMD_ALERT_MASK:  rd_nxt = {cml_mask_r, vend_mask_r};
      `PST_CMD_STATUS_BYTE: rd_nxt = {8'h00, status_byte_out};
      default:              um_nxt = 1'b1;
    endcase
  end

  // ==========================================================
  // Summary and alert next values
  reg [7:0] sb_nxt;
  reg       alert_n_nxt;

  // Only the comm summary bit is kept here; others read zero
  always @* begin
    sb_nxt = `PST_STAT_RESET;
    sb_nxt[`PST_BIT_SB_CML] = |cml_q;
  end

  // Alert is a level; it drops once every unmasked flag is gone
  always @* begin
    if (vend_alert | cml_alert) begin
      alert_n_nxt = 1'b0;
    end else begin
      alert_n_nxt = 1'b1;
    end
  end

  always @(posedge clock_in) begin
    if (!rst_n_in) begin
      rdata_out       <= 16'h0000;
      rvalid_out      <= 1'b0;
      unmapped_out    <= 1'b0;
      alert_n_out     <= 1'b1;
      status_byte_out <= `PST_STAT_RESET;
    end else begin
      rvalid_out   <= cmd_rd_in;
      unmapped_out <= cmd_rd_in & um_nxt;
      if (cmd_rd_in) begin
        rdata_out <= rd_nxt;
      end
      // Summary follows the comm latches one cycle late, and clears a cycle after them
      status_byte_out <= sb_nxt;
      alert_n_out     <= alert_n_nxt;
    end
  end
endmodule
`default_nettype wire

// *** testbench/pst_host_model.sv ***
// Host side model: one-cycle command strobes and reads
`timescale 1ns/1ps
`default_nettype none
module pst_host_model (
  input  wire logic [0:0]  clock_in,
  input  wire logic [15:0] rdata_in,
  output var logic         cmd_wr_out = 1'b0,
  output var logic         cmd_rd_out = 1'b0,
  output var logic [7:0]   cmd_code_out = 8'h00,
  output var logic [15:0]  cmd_wdata_out = 16'h0000
);
  // Idle lines carry inverted values so stale data cannot pass
  task automatic wr(input logic [7:0] c, input logic [15:0] w);
    @(posedge clock_in);
    {cmd_wr_out, cmd_code_out, cmd_wdata_out} <= {1'b1, c, w};
    @(posedge clock_in);
    {cmd_wr_out, cmd_code_out, cmd_wdata_out} <= {1'b0, ~c, ~w};
  endtask
  task automatic rd(input logic [7:0] c, output logic [15:0] d);
    @(posedge clock_in);
    {cmd_rd_out, cmd_code_out} <= {1'b1, c};
    @(posedge clock_in);
    {cmd_rd_out, cmd_code_out} <= {1'b0, ~c};
    #1 d = rdata_in;
  endtask
endmodule
`default_nettype wire

// *** testbench/pst_status_telemetry_sva.sv ***
// Checker on the command port and status outputs
`timescale 1ns/1ps
`default_nettype none
module pst_chk (
  input wire        clock_in,
  input wire        rst_n_in,
  input wire        cmd_wr_in,
  input wire        cmd_rd_in,
  input wire [7:0]  cmd_code_in,
  input wire        self_check_busy_in,
  input wire [15:0] rdata_out,
  input wire        rvalid_out,
  input wire        unmapped_out,
  input wire [7:0]  status_byte_out
);
  logic [7:0] code_q = 8'h00;
  wire        v80 = rvalid_out && code_q == 8'h80;
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  always @(posedge clock_in) if (cmd_rd_in) code_q <= cmd_code_in;
  rd_answer_a: assert property (cmd_rd_in |=> rvalid_out)
    else $error("read not answered");
  no_spur_a: assert property (!cmd_rd_in |=> !rvalid_out)
    else $error("read answer without request");
  unmap_zero_a: assert property (unmapped_out |-> rvalid_out && !rdata_out)
    else $error("unmapped read not zero");
  vend_zero_a: assert property (v80 |-> !(rdata_out & 16'hff31))
    else $error("vendor zero bits set");
  self_live_a: assert property (v80 && $past(self_check_busy_in)
    |-> rdata_out[6]) else $error("self check bit low");
  vin_ro_a: assert property (cmd_wr_in && cmd_code_in == 8'h88
    |-> ##2 status_byte_out[1]) else $error("no fault on read-only write");
  sb_only_a: assert property (!(status_byte_out & 8'hfd))
    else $error("summary stray bit");
  sb_cause_a: assert property ($rose(status_byte_out[1])
    |-> $past(cmd_wr_in, 2)) else $error("summary set without write");
  rd_hold_a: assert property (!rvalid_out |-> $stable(rdata_out))
    else $error("read data moved");
  cover property (v80 && rdata_out[7]);
  cover property (cmd_wr_in && cmd_code_in == 8'h88);
  cover property (unmapped_out);
endmodule
bind pst_status_telemetry pst_chk u_chk (.clock_in(clock_in),
  .rst_n_in(rst_n_in), .cmd_wr_in(cmd_wr_in), .cmd_rd_in(cmd_rd_in),
  .cmd_code_in(cmd_code_in), .self_check_busy_in(self_check_busy_in),
  .rdata_out(rdata_out), .rvalid_out(rvalid_out),
  .unmapped_out(unmapped_out), .status_byte_out(status_byte_out));
`default_nettype wire

// *** testbench/tb.sv ***
// Self-checking bench for the status and telemetry bank
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clock_in = 1'b0, rst_n_in = 1'b0, busy = 1'b0, smp = 1'b0;
  logic fol = 1'b0, wr, rd, alert_n, rv, um;
  logic [5:0] ev = 6'h00;
  logic [3:0] ans = 4'h3;
  logic [7:0] ph = 8'hff, code, sb;
  logic [15:0] tv = 16'h0000, d, x, wd, rdata;
  int n_errors = 0, samples_checked = 0, cyc = 0;
  localparam logic [31:0] ROWS [7] = '{32'h88ff1234, 32'h88021236,
    32'h88070000, 32'h8bffedcb, 32'h80ff0000, 32'h7eff0000, 32'h55ff0000};
  always #2 clock_in = ~clock_in;
  pst_host_model h (.clock_in(clock_in), .rdata_in(rdata), .cmd_wr_out(wr),
    .cmd_rd_out(rd), .cmd_code_out(code), .cmd_wdata_out(wd));
  pst_status_telemetry #(.STACK(4)) DUT (.clock_in(clock_in),
    .rst_n_in(rst_n_in), .cmd_wr_in(wr), .cmd_rd_in(rd),
    .cmd_code_in(code), .cmd_wdata_in(wd), .phase_in(ph),
    .trim_bad_in(ev[5]), .store_sum_bad_in(ev[4]), .pin_detect_bad_in(ev[3]),
    .self_check_busy_in(busy), .follower_expected_in(4'h3),
    .follower_answered_in(ans), .output_restart_event_in(ev[2]),
    .back_channel_link_fault_in(ev[1]), .sync_fault_in(ev[0]),
    .sample_done_in(smp), .vin_local_in(tv),
    .vin_stack_in({tv + 16'h3, tv + 16'h2, tv + 16'h1, tv}),
    .vout_linear_in(~tv), .output_sense_pin_in(tv ^ 16'h00ff),
    .loop_follower_in(fol), .rdata_out(rdata), .rvalid_out(rv),
    .unmapped_out(um), .alert_n_out(alert_n), .status_byte_out(sb));
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value at %0t: %h vs %h", $time, g, e);
    end
  endtask
  task automatic pulse(input logic [5:0] e);
    @(posedge clock_in) ev <= e;
    @(posedge clock_in) ev <= 6'h00;
    repeat (2) @(posedge clock_in);
  endtask
  task automatic rdc(input logic [7:0] c, input logic [15:0] e);
    h.rd(c, d);
    chk(d, e);
    chk({rv, um, 14'h0000}, {1'b1, c == 8'h55, 14'h0000});
  endtask
  task automatic summarize();
    if (n_errors == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clock_in);
    rst_n_in <= 1'b1;
    chk({alert_n, sb, 7'h00}, 16'h8000);
    @(posedge clock_in) {tv, smp} <= {16'h1234, 1'b1};
    @(posedge clock_in) {tv, smp} <= {16'h5555, 1'b0};
    foreach (ROWS[i]) begin
      @(posedge clock_in) ph <= ROWS[i][23:16];
      rdc(ROWS[i][31:24], ROWS[i][15:0]);
    end
    @(posedge clock_in) {fol, smp} <= 2'b11;
    @(posedge clock_in) smp <= 1'b0;
    rdc(8'h8b, 16'h55aa);
    for (int i = 0; i < 6; i++) begin
      x = (i > 2) ? 16'h0080 : 16'h0002 << i;
      pulse(6'h01 << i);
      chk(16'(alert_n), 16'h0000);
      h.wr(8'h80, 16'h0000);
      rdc(8'h80, x);
      h.wr(8'h80, x);
      h.rd(8'h80, d);
      chk({alert_n, d[14:0]}, 16'h8000);
    end
    h.wr(8'h1b, 16'h0008);
    pulse(6'h04);
    chk(16'(alert_n), 16'h0001);
    h.wr(8'h03, 16'h0000);
    rdc(8'h80, 16'h0000);
    h.wr(8'h1b, 16'h0000);
    @(posedge clock_in) busy <= 1'b1;
    rdc(8'h80, 16'h0040);
    @(posedge clock_in) {busy, ans} <= 5'h01;
    rdc(8'h80, 16'h0040);
    @(posedge clock_in) ans <= 4'h3;
    rdc(8'h80, 16'h0000);
    h.wr(8'h88, 16'hffff);
    h.rd(8'h7e, d);
    chk({d[7:0], sb[1], alert_n, 6'h00}, 16'h8080);
    h.wr(8'h7e, 16'h0080);
    h.rd(8'h7e, d);
    chk({d[7:0], sb[1], alert_n, 6'h00}, 16'h0040);
    h.wr(8'h8b, 16'h0001);
    h.wr(8'h03, 16'h0000);
    rdc(8'h7e, 16'h0000);
    @(posedge clock_in) ev <= 6'h01;
    h.wr(8'h80, 16'h0002);
    rdc(8'h80, 16'h0002);
    summarize();
  end
  // Run needs about 150 cycles; the ceiling at 5000 leaves margin
  always @(posedge clock_in) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_errors++;
      summarize();
    end
  end
endmodule
`default_nettype wire
